// *** rtl/uart_feature_pkg.sv ***
/*
 * Constants for the UART feature register block: register indices,
 * field positions, reset values, FIFO size and timing figures.
 * Assumes a single 100 MHz device clock.
 */
package uart_feature_pkg;

	// Register indices on the register port
	localparam logic [3:0] ADDR_RX_FLOW_THRESHOLD  = 4'h0;
	localparam logic [3:0] ADDR_FIFO_TRIGGER       = 4'h1;
	localparam logic [3:0] ADDR_TX_FREE_SPACE      = 4'h2;
	localparam logic [3:0] ADDR_RX_FILL_COUNT      = 4'h3;
	localparam logic [3:0] ADDR_PIN_DIRECTION      = 4'h4;
	localparam logic [3:0] ADDR_PIN_LEVEL          = 4'h5;
	localparam logic [3:0] ADDR_PIN_IRQ_ENABLE     = 4'h6;
	localparam logic [3:0] ADDR_PIN_FUNCTION       = 4'h7;
	localparam logic [3:0] ADDR_EXTRA_FEATURES     = 4'h8;
	localparam logic [3:0] ADDR_BAUD_DIV_LOW       = 4'h9;
	localparam logic [3:0] ADDR_BAUD_DIV_HIGH      = 4'hA;
	localparam logic [3:0] ADDR_BAUD_FRACTION      = 4'hB;

	// Reset values
	localparam logic [7:0] RST_RX_FLOW_THRESHOLD = 8'h0F;
	localparam logic [7:0] RST_FIFO_TRIGGER      = 8'h00;
	localparam logic [7:0] RST_BAUD_DIV_LOW      = 8'h01;
	localparam logic [7:0] RST_BAUD_DIV_HIGH     = 8'h00;
	localparam logic [7:0] RST_BAUD_FRACTION     = 8'h00;
	localparam logic [7:0] RST_ZERO              = 8'h00;

	// Pin function control fields
	localparam int PFC_LATCH      = 0;
	localparam int PFC_MODEM_A    = 1;
	localparam int PFC_MODEM_B    = 2;
	localparam int PFC_SOFT_RESET = 3;
	localparam logic [7:0] PFC_STORED_MASK = 8'h07;

	// Extra line feature fields
	localparam int ELF_NINE_BIT   = 0;
	localparam int ELF_RX_DISABLE = 1;
	localparam int ELF_TX_DISABLE = 2;
	localparam int ELF_RS485_EN   = 4;
	localparam int ELF_RS485_INV  = 5;
	localparam int ELF_IR_FAST    = 7;
	localparam logic [7:0] ELF_STORED_MASK = 8'hB7;

	// Baud fraction fields
	localparam logic [7:0] FRAC_STORED_MASK = 8'h3F;
	localparam int FRAC_SAMPLE_LO = 4;
	localparam int FRAC_SAMPLE_HI = 5;

	// FIFO size and count width
	localparam int          FIFO_DEPTH = 64;
	localparam int          CNT_W      = 7;
	localparam logic [1:0]  LEVEL_PAD  = 2'b00;

	// Legacy trigger choices selected by the fifo control register
	localparam logic [CNT_W-1:0] TX_TRIG_SEL0 = 7'h08;
	localparam logic [CNT_W-1:0] TX_TRIG_SEL1 = 7'h10;
	localparam logic [CNT_W-1:0] TX_TRIG_SEL2 = 7'h20;
	localparam logic [CNT_W-1:0] TX_TRIG_SEL3 = 7'h38;
	localparam logic [CNT_W-1:0] RX_TRIG_SEL0 = 7'h08;
	localparam logic [CNT_W-1:0] RX_TRIG_SEL1 = 7'h10;
	localparam logic [CNT_W-1:0] RX_TRIG_SEL2 = 7'h38;
	localparam logic [CNT_W-1:0] RX_TRIG_SEL3 = 7'h3C;

	// Receive timeout
	localparam int CLOCK_MHZ         = 100;
	localparam int RX_TIMEOUT_US     = 40;
	localparam int RX_TIMEOUT_CYCLES = RX_TIMEOUT_US * CLOCK_MHZ;
	localparam int TIMEOUT_W         = 13;

	// Receive sampling rate
	typedef enum logic [1:0] {
		SAMPLE_16X = 2'b00,
		SAMPLE_8X  = 2'b01,
		SAMPLE_4X  = 2'b10
	} sample_rate_t;

endpackage : uart_feature_pkg

// *** rtl/uart_feature_regs.sv ***
/*
 * Configuration and status registers of one UART channel pair: flow
 * threshold, FIFO triggers and levels, eight general-purpose pins with
 * modem multiplexing, extra line features and the fractional divisor.
 * Assumes the rest of the UART supplies FIFO counts, busy flags and the
 * enhanced-function enable, and that every input is synchronous.
 */
`timescale 1ns/100ps

module uart_feature_regs
	import uart_feature_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = RX_TIMEOUT_CYCLES
) (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic [3:0]            regAddr,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	input  wire logic [7:0]            regWdata,
	output logic      [7:0]            regRdata,
	input  wire logic                  enhancedEnable,
	input  wire logic [1:0]            txTrigSelect,
	input  wire logic [1:0]            rxTrigSelect,
	input  wire logic                  autoRtsEnable,
	input  wire logic                  autoXonEnable,
	input  wire logic [CNT_W-1:0]      txFifoCount,
	input  wire logic [CNT_W-1:0]      rxFifoCount,
	input  wire logic                  rxLineIdle,
	input  wire logic                  txShiftBusy,
	input  wire logic                  rxShiftBusy,
	input  wire logic                  txActive,
	output logic                       rtsN,
	output logic                       xonRequest,
	output logic                       txReadyIrq,
	output logic                       rxReadyIrq,
	output logic                       rxTimeoutIrq,
	input  wire logic [7:0]            gpioIn,
	output logic      [7:0]            gpioOut,
	output logic      [7:0]            gpioOe,
	output logic                       gpioIrq,
	input  wire logic                  terminal_ready_a_n,
	input  wire logic                  terminal_ready_b_n,
	output logic                       ring_indicate_a_n,
	output logic                       carrier_detect_a_n,
	output logic                       set_ready_a_n,
	output logic                       ring_indicate_b_n,
	output logic                       carrier_detect_b_n,
	output logic                       set_ready_b_n,
	output logic                       irFastMode,
	output logic                       txEnable,
	output logic                       rxEnable,
	output logic                       nineBitMode,
	output logic      [15:0]           divisorInt,
	output logic      [3:0]            divisorFrac,
	output sample_rate_t               sampleRate
);

	// Software registers
	logic [7:0] flowThr_q, flowThr_d;
	logic [7:0] trig_q, trig_d;
	logic [7:0] pinDir_q, pinDir_d;
	logic [7:0] pinOutVal_q, pinOutVal_d;
	logic [7:0] pinIrqEn_q, pinIrqEn_d;
	logic [7:0] pinFunc_q, pinFunc_d;
	logic [7:0] features_q, features_d;
	logic [7:0] divLow_q, divLow_d;
	logic [7:0] divHigh_q, divHigh_d;
	logic [7:0] frac_q, frac_d;

	// Block state
	logic [7:0]           pinRef_q, pinRef_d;
	logic [7:0]           pinLatched_q, pinLatched_d;
	logic [7:0]           pinPend_q, pinPend_d;
	logic                 flowHalted_q, flowHalted_d;
	logic [TIMEOUT_W-1:0] idleCnt_q, idleCnt_d;

	// Registered outputs
	logic [7:0]   rdata_d;
	logic         rts_d, xon_d, txIrq_d, rxIrq_d, toIrq_d;
	logic [7:0]   gOut_d, gOe_d;
	logic         gIrq_d;
	logic         txEn_d, rxEn_d;
	sample_rate_t rate_d;

	// Derived levels
	logic [CNT_W-1:0] haltLevel, resumeLevel, txTrig, rxTrig, txFree;
	logic [7:0]       pinView, irqMask, changed;
	logic             writeHit, readLevel, modemA, modemB, flowRts;
	logic [TIMEOUT_W-1:0] timeoutLimit;

	always_comb begin
		haltLevel   = {1'b0, flowThr_q[3:0], LEVEL_PAD};
		resumeLevel = {1'b0, flowThr_q[7:4], LEVEL_PAD};
		txFree      = CNT_W'(FIFO_DEPTH) - txFifoCount;
		if (trig_q[3:0] != 4'h0) begin
			txTrig = {1'b0, trig_q[3:0], LEVEL_PAD};
		end else begin
			unique case (txTrigSelect)
				2'b00: txTrig = TX_TRIG_SEL0;
				2'b01: txTrig = TX_TRIG_SEL1;
				2'b10: txTrig = TX_TRIG_SEL2;
				2'b11: txTrig = TX_TRIG_SEL3;
			endcase
		end
		if (trig_q[7:4] != 4'h0) begin
			rxTrig = {1'b0, trig_q[7:4], LEVEL_PAD};
		end else begin
			unique case (rxTrigSelect)
				2'b00: rxTrig = RX_TRIG_SEL0;
				2'b01: rxTrig = RX_TRIG_SEL1;
				2'b10: rxTrig = RX_TRIG_SEL2;
				2'b11: rxTrig = RX_TRIG_SEL3;
			endcase
		end
		modemA       = pinFunc_q[PFC_MODEM_A];
		modemB       = pinFunc_q[PFC_MODEM_B];
		writeHit     = regWrite;
		readLevel    = regRead && (regAddr == ADDR_PIN_LEVEL);
		timeoutLimit = TIMEOUT_W'(TIMEOUT_CYCLES);
		// Latched mode shows the captured level of input pins
		pinView = pinFunc_q[PFC_LATCH] ? pinLatched_q : gpioIn;
		irqMask = ~pinDir_q;
		if (modemA) begin
			irqMask[7:4] = 4'h0;
		end
		if (modemB) begin
			irqMask[3:0] = 4'h0;
		end
		changed = gpioIn ^ pinRef_q;
	end

	// Register writes to the software registers
	always_comb begin
		flowThr_d    = flowThr_q;
		trig_d       = trig_q;
		pinDir_d     = pinDir_q;
		pinOutVal_d  = pinOutVal_q;
		pinIrqEn_d   = pinIrqEn_q;
		pinFunc_d    = pinFunc_q;
		features_d   = features_q;
		divLow_d     = divLow_q;
		divHigh_d    = divHigh_q;
		frac_d       = frac_q;
		if (writeHit) begin
			unique case (regAddr)
				ADDR_RX_FLOW_THRESHOLD: begin
					if (enhancedEnable) begin
						flowThr_d = regWdata;
					end
				end
				ADDR_FIFO_TRIGGER: begin
					if (enhancedEnable) begin
						trig_d = regWdata;
					end
				end
				ADDR_PIN_DIRECTION:  pinDir_d    = regWdata;
				ADDR_PIN_LEVEL:      pinOutVal_d = regWdata;
				ADDR_PIN_IRQ_ENABLE: pinIrqEn_d  = regWdata;
				ADDR_PIN_FUNCTION: begin
					pinFunc_d = regWdata & PFC_STORED_MASK;
					if (regWdata[PFC_SOFT_RESET]) begin
						pinFunc_d[PFC_MODEM_A] = 1'b0;
						pinFunc_d[PFC_MODEM_B] = 1'b0;
					end
				end
				ADDR_EXTRA_FEATURES: features_d = regWdata & ELF_STORED_MASK;
				ADDR_BAUD_DIV_LOW:   divLow_d   = regWdata;
				ADDR_BAUD_DIV_HIGH:  divHigh_d  = regWdata;
				ADDR_BAUD_FRACTION: begin
					if (enhancedEnable) begin
						frac_d = regWdata & FRAC_STORED_MASK;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Pin change tracking
	always_comb begin
		pinRef_d     = pinRef_q;
		pinLatched_d = pinLatched_q;
		pinPend_d    = pinPend_q;
		if (pinFunc_q[PFC_LATCH]) begin
			// Change is captured and held until the level read
			for (int i = 0; i < 8; i++) begin
				if (changed[i] && !pinPend_q[i]) begin
					pinLatched_d[i] = gpioIn[i];
					pinPend_d[i]    = 1'b1;
				end
			end
			if (readLevel) begin
				pinRef_d     = pinLatched_q;
				pinPend_d    = 8'h00;
				pinLatched_d = gpioIn;
			end
		end else begin
			// Pending follows the difference, so a revert clears it
			pinLatched_d = gpioIn;
			pinPend_d    = readLevel ? 8'h00 : changed;
			if (readLevel) begin
				pinRef_d = gpioIn;
			end
		end
	end

	// Flow control and interrupts
	always_comb begin
		flowHalted_d = flowHalted_q;
		xon_d        = 1'b0;
		if (!flowHalted_q && rxFifoCount >= haltLevel) begin
			flowHalted_d = 1'b1;
		end else if (flowHalted_q && rxFifoCount <= resumeLevel) begin
			flowHalted_d = 1'b0;
			xon_d        = autoXonEnable;
		end
		flowRts = autoRtsEnable & flowHalted_q;
		if (features_q[ELF_RS485_EN]) begin
			rts_d = ~(txActive ^ features_q[ELF_RS485_INV]);
		end else begin
			rts_d = flowRts;
		end
		txIrq_d = txFree >= txTrig;
		rxIrq_d = rxFifoCount >= rxTrig;
		if (rxFifoCount == '0 || !rxLineIdle) begin
			idleCnt_d = '0;
		end else if (idleCnt_q != timeoutLimit) begin
			idleCnt_d = idleCnt_q + TIMEOUT_W'(1);
		end else begin
			idleCnt_d = idleCnt_q;
		end
		toIrq_d = idleCnt_d == timeoutLimit;
		gIrq_d  = |(pinPend_d & pinIrqEn_q & irqMask);
	end

	// Pins, line controls and read data
	always_comb begin
		gOe_d  = pinDir_q;
		gOut_d = pinOutVal_q;
		if (modemB) begin
			gOut_d[1] = terminal_ready_b_n;
		end
		if (modemA) begin
			gOut_d[5] = terminal_ready_a_n;
		end
		if (!features_q[ELF_TX_DISABLE]) begin
			txEn_d = 1'b1;
		end else begin
			txEn_d = txEnable & txShiftBusy;
		end
		if (!features_q[ELF_RX_DISABLE]) begin
			rxEn_d = 1'b1;
		end else begin
			rxEn_d = rxEnable & rxShiftBusy;
		end
		if (frac_q[FRAC_SAMPLE_HI]) begin
			rate_d = SAMPLE_4X;
		end else if (frac_q[FRAC_SAMPLE_LO]) begin
			rate_d = SAMPLE_8X;
		end else begin
			rate_d = SAMPLE_16X;
		end
		rdata_d = 8'h00;
		if (regRead) begin
			unique case (regAddr)
				ADDR_RX_FLOW_THRESHOLD: rdata_d = flowThr_q;
				ADDR_FIFO_TRIGGER:      rdata_d = trig_q;
				ADDR_TX_FREE_SPACE:     rdata_d = {1'b0, txFree};
				ADDR_RX_FILL_COUNT:     rdata_d = {1'b0, rxFifoCount};
				ADDR_PIN_DIRECTION:     rdata_d = pinDir_q;
				ADDR_PIN_LEVEL:         rdata_d = pinView;
				ADDR_PIN_IRQ_ENABLE:    rdata_d = pinIrqEn_q;
				ADDR_PIN_FUNCTION:      rdata_d = pinFunc_q;
				ADDR_EXTRA_FEATURES:    rdata_d = features_q;
				ADDR_BAUD_DIV_LOW:      rdata_d = divLow_q;
				ADDR_BAUD_DIV_HIGH:     rdata_d = divHigh_q;
				ADDR_BAUD_FRACTION:     rdata_d = frac_q;
				default:                rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flowThr_q    <= RST_RX_FLOW_THRESHOLD;
			trig_q       <= RST_FIFO_TRIGGER;
			pinDir_q     <= RST_ZERO;
			pinOutVal_q  <= RST_ZERO;
			pinIrqEn_q   <= RST_ZERO;
			pinFunc_q    <= RST_ZERO;
			features_q   <= RST_ZERO;
			divLow_q     <= RST_BAUD_DIV_LOW;
			divHigh_q    <= RST_BAUD_DIV_HIGH;
			frac_q       <= RST_BAUD_FRACTION;
			pinRef_q     <= RST_ZERO;
			pinLatched_q <= RST_ZERO;
			pinPend_q    <= RST_ZERO;
			flowHalted_q <= 1'b0;
			idleCnt_q    <= '0;
			regRdata     <= RST_ZERO;
			rtsN         <= 1'b0;
			xonRequest   <= 1'b0;
			txReadyIrq   <= 1'b0;
			rxReadyIrq   <= 1'b0;
			rxTimeoutIrq <= 1'b0;
			gpioOut      <= RST_ZERO;
			gpioOe       <= RST_ZERO;
			gpioIrq      <= 1'b0;
			txEnable     <= 1'b1;
			rxEnable     <= 1'b1;
			sampleRate   <= SAMPLE_16X;
		end else begin
			flowThr_q    <= flowThr_d;
			trig_q       <= trig_d;
			pinDir_q     <= pinDir_d;
			pinOutVal_q  <= pinOutVal_d;
			pinIrqEn_q   <= pinIrqEn_d;
			pinFunc_q    <= pinFunc_d;
			features_q   <= features_d;
			divLow_q     <= divLow_d;
			divHigh_q    <= divHigh_d;
			frac_q       <= frac_d;
			pinRef_q     <= pinRef_d;
			pinLatched_q <= pinLatched_d;
			pinPend_q    <= pinPend_d;
			flowHalted_q <= flowHalted_d;
			idleCnt_q    <= idleCnt_d;
			regRdata     <= rdata_d;
			rtsN         <= rts_d;
			xonRequest   <= xon_d;
			txReadyIrq   <= txIrq_d;
			rxReadyIrq   <= rxIrq_d;
			rxTimeoutIrq <= toIrq_d;
			gpioOut      <= gOut_d;
			gpioOe       <= gOe_d;
			gpioIrq      <= gIrq_d;
			txEnable     <= txEn_d;
			rxEnable     <= rxEn_d;
			sampleRate   <= rate_d;
		end
	end

	// Modem inputs and line options follow the registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ring_indicate_a_n  <= 1'b1;
			carrier_detect_a_n <= 1'b1;
			set_ready_a_n      <= 1'b1;
			ring_indicate_b_n  <= 1'b1;
			carrier_detect_b_n <= 1'b1;
			set_ready_b_n      <= 1'b1;
			irFastMode         <= 1'b0;
			nineBitMode        <= 1'b0;
			divisorInt         <= {RST_BAUD_DIV_HIGH, RST_BAUD_DIV_LOW};
			divisorFrac        <= RST_BAUD_FRACTION[3:0];
		end else begin
			ring_indicate_a_n  <= modemA ? gpioIn[7] : 1'b1;
			carrier_detect_a_n <= modemA ? gpioIn[6] : 1'b1;
			set_ready_a_n      <= modemA ? gpioIn[4] : 1'b1;
			ring_indicate_b_n  <= modemB ? gpioIn[3] : 1'b1;
			carrier_detect_b_n <= modemB ? gpioIn[2] : 1'b1;
			set_ready_b_n      <= modemB ? gpioIn[0] : 1'b1;
			irFastMode         <= features_q[ELF_IR_FAST];
			nineBitMode        <= features_q[ELF_NINE_BIT];
			divisorInt         <= {divHigh_q, divLow_q};
			divisorFrac        <= frac_q[3:0];
		end
	end

endmodule : uart_feature_regs

// *** testbench/uart_pin_partner.sv ***
/*
 * Remote side of the eight general-purpose pins.
 * Assumes the device enables are high while the device drives a pin.
 */
`timescale 1ns/100ps
module uart_pin_partner (
	input  wire logic [7:0] gpioOut,
	input  wire logic [7:0] gpioOe,
	input  wire logic [7:0] extLevel,
	output logic      [7:0] gpioIn
);
	// Driven pins carry the device level, the rest the remote level
	always_comb begin
		for (int i = 0; i < 8; i++)
			gpioIn[i] = gpioOe[i] ? gpioOut[i] : extLevel[i];
	end
endmodule : uart_pin_partner

// *** testbench/uart_feature_regs_properties.sv ***
/*
 * Port checks for the feature register block.
 * Assumes each strobe is followed by one idle cycle.
 */
`timescale 1ns/100ps
module uart_feature_checker
	import uart_feature_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = RX_TIMEOUT_CYCLES
) (
	input wire logic             clock,
	input wire logic             rst_n,
	input wire logic [3:0]       regAddr,
	input wire logic             regWrite,
	input wire logic             regRead,
	input wire logic [7:0]       regWdata,
	input wire logic [7:0]       regRdata,
	input wire logic             enhancedEnable,
	input wire logic [CNT_W-1:0] txFifoCount,
	input wire logic [CNT_W-1:0] rxFifoCount,
	input wire logic             rxLineIdle,
	input wire logic             rxTimeoutIrq,
	input wire logic [7:0]       gpioOe,
	input wire logic             gpioIrq,
	input wire logic             ring_indicate_a_n,
	input wire logic             ring_indicate_b_n,
	input wire logic             irFastMode,
	input wire logic             nineBitMode,
	input wire logic [15:0]      divisorInt,
	input wire logic [3:0]       divisorFrac,
	input wire sample_rate_t     sampleRate
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Cycles with data waiting on an idle line
	int idleCnt;
	always_ff @(posedge clock) begin
		if (!rst_n || rxFifoCount == 7'h00 || !rxLineIdle)
			idleCnt <= 0;
		else if (idleCnt < 1000)
			idleCnt <= idleCnt + 1;
	end

	property p_read_idle;
		regRdata != 8'h00 |-> $past(regRead);
	endproperty
	a_read_idle: assert property (p_read_idle)
		else $error("read data without a read");
	property p_rx_fill;
		regRead && regAddr == ADDR_RX_FILL_COUNT
			|=> regRdata == {1'b0, $past(rxFifoCount)};
	endproperty
	a_rx_fill: assert property (p_rx_fill)
		else $error("fill count read wrong");
	property p_tx_free;
		regRead && regAddr == ADDR_TX_FREE_SPACE
			|=> regRdata == 8'h40 - {1'b0, $past(txFifoCount)};
	endproperty
	a_tx_free: assert property (p_tx_free)
		else $error("free space read wrong");
	property p_direction;
		regWrite && regAddr == ADDR_PIN_DIRECTION ##1 !regWrite
			|=> gpioOe == $past(regWdata, 2);
	endproperty
	a_direction: assert property (p_direction)
		else $error("pin enables do not follow direction");
	property p_features;
		regWrite && regAddr == ADDR_EXTRA_FEATURES ##1 !regWrite
			|=> irFastMode == $past(regWdata[ELF_IR_FAST], 2)
			&& nineBitMode == $past(regWdata[ELF_NINE_BIT], 2);
	endproperty
	a_features: assert property (p_features)
		else $error("feature outputs wrong");
	property p_div_low;
		regWrite && regAddr == ADDR_BAUD_DIV_LOW ##1 !regWrite
			|=> divisorInt[7:0] == $past(regWdata, 2);
	endproperty
	a_div_low: assert property (p_div_low)
		else $error("divisor low byte wrong");
	property p_fraction;
		regWrite && enhancedEnable && regAddr == ADDR_BAUD_FRACTION
			##1 !regWrite |=> divisorFrac == $past(regWdata[3:0], 2)
			&& sampleRate == ($past(regWdata[5], 2) ? SAMPLE_4X
			: $past(regWdata[4], 2) ? SAMPLE_8X : SAMPLE_16X);
	endproperty
	a_fraction: assert property (p_fraction)
		else $error("fraction or sampling wrong");
	property p_frac_locked;
		regWrite && !enhancedEnable && regAddr == ADDR_BAUD_FRACTION
			##1 !regWrite |=> $stable(divisorFrac) && $stable(sampleRate);
	endproperty
	a_frac_locked: assert property (p_frac_locked)
		else $error("locked fraction changed");
	property p_level_clear;
		regRead && regAddr == ADDR_PIN_LEVEL |=> !gpioIrq;
	endproperty
	a_level_clear: assert property (p_level_clear)
		else $error("pin interrupt kept after level read");
	property p_soft_reset;
		regWrite && regAddr == ADDR_PIN_FUNCTION
			&& regWdata[PFC_SOFT_RESET] ##1 !regWrite
			|=> ring_indicate_a_n && ring_indicate_b_n;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("modem selects survive soft reset");
	property p_timeout;
		idleCnt > TIMEOUT_CYCLES + 2 |-> rxTimeoutIrq;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("receive timeout missing");
endmodule : uart_feature_checker

bind uart_feature_regs uart_feature_checker #(
	.TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) checker_i (
	.clock, .rst_n, .regAddr, .regWrite, .regRead, .regWdata,
	.regRdata, .enhancedEnable, .txFifoCount, .rxFifoCount,
	.rxLineIdle, .rxTimeoutIrq, .gpioOe, .gpioIrq,
	.ring_indicate_a_n, .ring_indicate_b_n, .irFastMode,
	.nineBitMode, .divisorInt, .divisorFrac, .sampleRate
);

// *** testbench/test_uart_feature_regs.sv ***
/*
 * Self-checking bench for the feature register block.
 * Assumes the pin partner model and the bound checker.
 */
`timescale 1ns/100ps
module test_uart_feature_regs;
	import uart_feature_pkg::*;

	logic             clock, rst_n, regWrite, regRead, enhancedEnable;
	logic             autoRtsEnable, autoXonEnable, rxLineIdle, txActive;
	logic             txShiftBusy, rxShiftBusy, rtsN, xonRequest;
	logic             txReadyIrq, rxReadyIrq, rxTimeoutIrq, gpioIrq;
	logic             terminal_ready_a_n, terminal_ready_b_n;
	logic             ring_indicate_a_n, carrier_detect_a_n, set_ready_a_n;
	logic             ring_indicate_b_n, carrier_detect_b_n, set_ready_b_n;
	logic             irFastMode, txEnable, rxEnable, nineBitMode;
	logic [1:0]       txTrigSelect, rxTrigSelect;
	logic [3:0]       regAddr, divisorFrac, a;
	logic [7:0]       regWdata, regRdata, gpioOut, gpioOe, extLevel, q, d, t;
	logic [CNT_W-1:0] txFifoCount, rxFifoCount;
	logic [15:0]      divisorInt;
	wire  [7:0]       gpioIn;
	sample_rate_t     sampleRate;
	logic [7:0]       sh [16];
	logic [3:0]       wa [6] = '{4'h0, 4'h1, 4'h3, 4'h9, 4'hA, 4'hB};
	logic [6:0]       fl [6] = '{7'h2C, 7'h0D, 7'h0C, 7'h27, 7'h28, 7'h0C};
	logic [0:5]       fe = 6'b110010;
	logic [7:0]       ef [4] = '{8'hFF, 8'h10, 8'h30, 8'h86};
	int               errCount, nCompared, seed, x, y;

	uart_feature_regs #(.TIMEOUT_CYCLES(8)) uut (
		.clock, .rst_n, .regAddr, .regWrite, .regRead, .regWdata,
		.regRdata, .enhancedEnable, .txTrigSelect, .rxTrigSelect,
		.autoRtsEnable, .autoXonEnable, .txFifoCount, .rxFifoCount,
		.rxLineIdle, .txShiftBusy, .rxShiftBusy, .txActive, .rtsN,
		.xonRequest, .txReadyIrq, .rxReadyIrq, .rxTimeoutIrq,
		.gpioIn, .gpioOut, .gpioOe, .gpioIrq, .terminal_ready_a_n,
		.terminal_ready_b_n, .ring_indicate_a_n, .carrier_detect_a_n,
		.set_ready_a_n, .ring_indicate_b_n, .carrier_detect_b_n,
		.set_ready_b_n, .irFastMode, .txEnable, .rxEnable,
		.nineBitMode, .divisorInt, .divisorFrac, .sampleRate
	);
	uart_pin_partner partner (.gpioOut, .gpioOe, .extLevel, .gpioIn);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task wr(input logic [3:0] ad, input logic [7:0] dt);
		regAddr = ad;
		regWdata = dt;
		regWrite = 1'b1;
		cyc(1);
		regWrite = 1'b0;
		cyc(1);
	endtask : wr
	task rd(input logic [3:0] ad);
		regAddr = ad;
		regRead = 1'b1;
		cyc(1);
		regRead = 1'b0;
		q = regRdata;
		cyc(1);
	endtask : rd
	task chk(input logic [15:0] s, input logic [15:0] e);
		nCompared++;
		if (s !== e) begin
			errCount++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task pinSet(input logic [7:0] ext, input logic irq);
		extLevel = ext;
		cyc(3);
		chk(gpioIrq, irq);
	endtask : pinSet
	task endTest(input string s);
		$display("test %s finished, %0d wrong so far", s, errCount);
	endtask : endTest
	task summarize;
		$display("compared %0d values, %0d wrong", nCompared, errCount);
		if (errCount == 0 && nCompared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	function automatic int trig(logic [3:0] n, logic [1:0] s, bit tx);
		int tab [2][4] = '{'{8, 16, 56, 60}, '{8, 16, 32, 56}};
		return (n != 4'h0) ? n * 4 : tab[tx][s];
	endfunction : trig

	initial begin
		repeat (20000) @(posedge clock);
		errCount++;
		summarize();
	end

	initial begin
		seed = 32'hF513;
		{regWrite, regRead, regAddr, regWdata, enhancedEnable, txTrigSelect,
		 rxTrigSelect, autoRtsEnable, autoXonEnable, txFifoCount, rxFifoCount,
		 txShiftBusy, rxShiftBusy, txActive, extLevel} = '0;
		{rst_n, rxLineIdle, terminal_ready_a_n, terminal_ready_b_n} = 4'h7;
		sh = '{0: 8'h0F, 2: 8'h40, 9: 8'h01, default: 8'h00};
		cyc(4);
		rst_n = 1'b1;
		for (int i = 0; i < 16; i++) begin
			rd(4'(i));
			chk(q, sh[i]);
		end
		endTest("reset");
		for (int i = 0; i < 30; i++) begin
			enhancedEnable = 1'($random(seed));
			a = wa[i % 6];
			d = 8'($random(seed));
			wr(a, d);
			if (enhancedEnable && a != 4'h3 || a == 4'h9 || a == 4'hA)
				sh[a] = (a == 4'hB) ? d & 8'h3F : d;
			rd(a);
			chk(q, sh[a]);
			chk(divisorInt, {sh[10], sh[9]});
		end
		enhancedEnable = 1'b1;
		endTest("lock");
		for (int i = 0; i < 16; i++) begin
			txFifoCount = 7'(i == 0 ? 0 : i == 1 ? 64 : {$random(seed)} % 65);
			rxFifoCount = 7'(i == 0 ? 64 : i == 1 ? 0 : {$random(seed)} % 65);
			{txTrigSelect, rxTrigSelect} = 4'($random(seed));
			t = (i < 4) ? 8'h00 : 8'($random(seed));
			wr(ADDR_FIFO_TRIGGER, t);
			rd(ADDR_TX_FREE_SPACE);
			chk(q, 8'h40 - 8'(txFifoCount));
			rd(ADDR_RX_FILL_COUNT);
			chk(q, 8'(rxFifoCount));
			x = trig(t[3:0], txTrigSelect, 1'b1);
			y = trig(t[7:4], rxTrigSelect, 1'b0);
			chk(txReadyIrq, 16'(64 - txFifoCount >= x));
			chk(rxReadyIrq, 16'(rxFifoCount >= y));
		end
		endTest("levels");
		wr(ADDR_FIFO_TRIGGER, 8'h40);
		wr(ADDR_RX_FLOW_THRESHOLD, 8'h3A);
		{autoRtsEnable, autoXonEnable} = 2'b11;
		for (int i = 0; i < 6; i++) begin
			rxFifoCount = fl[i];
			cyc(1);
			chk(xonRequest, i == 2 || i == 5);
			cyc(2);
			chk(rtsN, fe[i]);
		end
		{autoRtsEnable, autoXonEnable} = 2'b00;
		rxFifoCount = 7'h00;
		cyc(2);
		rxFifoCount = 7'h01;
		cyc(5);
		rxLineIdle = 1'b0;
		cyc(1);
		rxLineIdle = 1'b1;
		cyc(6);
		chk(rxTimeoutIrq, 1'b0);
		cyc(6);
		chk(rxTimeoutIrq, 1'b1);
		rxFifoCount = 7'h00;
		cyc(3);
		chk(rxTimeoutIrq, 1'b0);
		endTest("flow");
		for (int i = 0; i < 6; i++) begin
			d = 8'($random(seed));
			t = 8'($random(seed));
			extLevel = 8'($random(seed));
			wr(ADDR_PIN_DIRECTION, d);
			wr(ADDR_PIN_LEVEL, t);
			rd(ADDR_PIN_LEVEL);
			chk(gpioOe, d);
			chk(q, d & t | ~d & extLevel);
		end
		wr(ADDR_PIN_DIRECTION, 8'h00);
		extLevel = 8'h00;
		wr(ADDR_PIN_IRQ_ENABLE, 8'hFF);
		rd(ADDR_PIN_LEVEL);
		pinSet(8'h10, 1'b1);
		pinSet(8'h00, 1'b0);
		pinSet(8'h04, 1'b1);
		rd(ADDR_PIN_LEVEL);
		chk(q, 8'h04);
		wr(ADDR_PIN_FUNCTION, 8'h01);
		rd(ADDR_PIN_LEVEL);
		pinSet(8'h44, 1'b1);
		pinSet(8'h04, 1'b1);
		rd(ADDR_PIN_LEVEL);
		chk(q[6], 1'b1);
		endTest("pins");
		wr(ADDR_PIN_FUNCTION, 8'h00);
		wr(ADDR_PIN_LEVEL, 8'hFF);
		wr(ADDR_PIN_DIRECTION, 8'h22);
		wr(ADDR_PIN_IRQ_ENABLE, 8'hF0);
		wr(ADDR_PIN_FUNCTION, 8'h02);
		terminal_ready_a_n = 1'b0;
		rd(ADDR_PIN_LEVEL);
		pinSet(8'h84, 1'b0);
		chk({ring_indicate_a_n, carrier_detect_a_n}, 2'b10);
		chk(set_ready_a_n, 1'b0);
		chk(gpioOut[5], 1'b0);
		wr(ADDR_PIN_FUNCTION, 8'h06);
		terminal_ready_b_n = 1'b0;
		extLevel = 8'h04;
		cyc(3);
		chk({ring_indicate_b_n, carrier_detect_b_n}, 2'b01);
		chk(set_ready_b_n, 1'b0);
		chk(gpioOut[1], 1'b0);
		wr(ADDR_PIN_FUNCTION, 8'h0E);
		rd(ADDR_PIN_FUNCTION);
		chk(q, 8'h00);
		chk(ring_indicate_b_n, 1'b1);
		endTest("modem");
		{txShiftBusy, rxShiftBusy} = 2'b11;
		for (int i = 0; i < 8; i++) begin
			d = ef[i / 2];
			txActive = i[0];
			wr(ADDR_EXTRA_FEATURES, d);
			rd(ADDR_EXTRA_FEATURES);
			chk(q, d & 8'hB7);
			chk({irFastMode, nineBitMode}, {d[7], d[0]});
			chk({txEnable, rxEnable}, 2'b11);
			if (d[4])
				chk(rtsN, 1'(~(txActive ^ d[5])));
		end
		{txShiftBusy, rxShiftBusy} = 2'b00;
		cyc(2);
		chk({txEnable, rxEnable}, 2'(~d[2:1]));
		endTest("features");
		summarize();
	end
endmodule : test_uart_feature_regs
